// file: hdl/io_expander_port_interrupt_core.sv
// Port direction, input capture and interrupt logic of the SPI I/O expander.
// Behaviour
// - After any reset every pin is an input.
// - Each direction bit selects its own pin's direction.
// - Polarity bit set inverts the reported input value.
// - All registers readable except the write-only software reset.
// - Reset pin low, software reset or power-on reset restore defaults.
// - Every reset loads defaults and restarts the serial state machine; pin and software reset keep the fault bits.
// - Input pins float; output pins drive their output register bit.
// - Edge on an unmasked input sets its flag and asserts interrupt.
// - Outside fail-safe, interrupt stays asserted until all input-pin flags of every port and all fault bits clear.
// - Output pins never set flags nor assert interrupt.
// - Flag survives switch to output; interrupt returns when input again.
// - Output-to-input switch with differing level may raise interrupt.
// - Interrupt output is open-drain, active low.
// - Pin reset clears flags briefly; fail-safe entry clears and disables interrupt.
// - Writing mask bit one clears that pin's pending flag.
// - Smart clearing per port, enabled by a zero bit.
// - Smart, select high at change: return, input read or flag read clear.
// - Smart, select low at change: return or input read clear after hold.
// - Regular mode: return or input read leave the flag; reading flag status clears it.
// - Power-on recovery sets unmaskable fault bit; fault status read clears it.
// - Enabled redundancy mismatch sets sync fault; fault read clears it.
// - Inputs unmasked after reset; mask one keeps flag zero.
`timescale 1ns/1ns
module io_expander_port_interrupt_core (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Reset sources
	input  wire logic        reset_pin_n,
	input  wire logic        por_event,
	input  wire logic        sw_reset,
	// Serial interface chip select, active low, from the pin
	input  wire logic        cs_n,
	// Register writes from the serial decoder
	input  wire logic        dir_wr,
	input  wire logic [23:0] dir_wdata,
	input  wire logic        out_wr,
	input  wire logic [23:0] out_wdata,
	input  wire logic        pol_wr,
	input  wire logic [23:0] pol_wdata,
	input  wire logic        mask_wr,
	input  wire logic [23:0] mask_wdata,
	input  wire logic        smart_wr,
	input  wire logic [2:0]  smart_wdata,
	// Register read events from the serial decoder
	input  wire logic        input_rd,
	input  wire logic        flag_rd,
	input  wire logic        fault_rd,
	// Fail-safe
	input  wire logic        failsafe_enter,
	input  wire logic        redund_chk_en,
	input  wire logic        redund_mismatch,
	// Port pins
	input  wire logic [23:0] pin_in,
	output logic      [23:0] pin_out,
	output logic      [23:0] pin_oe,
	// Interrupt pin, open drain
	output logic             int_out,
	output logic             int_oe,
	// Register read back
	output logic      [23:0] dir_q,
	output logic      [23:0] out_q,
	output logic      [23:0] pol_q,
	output logic      [23:0] mask_q,
	output logic      [2:0]  smart_q,
	output logic      [23:0] input_q,
	output logic      [23:0] flag_q,
	output logic      [5:0]  fault_q,
	// Serial state machine restart
	output logic             spi_init
);
	// ****************************************
	// Reset combining
	// ****************************************
	logic        rst_pin_lvl;
	logic        rst_all;
	logic        por_seen_r;
	logic        por_seen_nxt;
	logic [23:0] pin_s;
	logic        cs_s;
	logic        cs_held;

	ioexp_sync #(.W(1)) u_rst_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.async_in (~reset_pin_n),
		.sync_out (rst_pin_lvl)
	);

	// Chip select resets high so a pending delayed clear never fires early.
	ioexp_sync #(.W(1)) u_cs_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.async_in (~cs_n),
		.sync_out (cs_s)
	);

	ioexp_sync #(.W(ioexp_pkg::PINS)) u_pin_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.async_in (pin_in),
		.sync_out (pin_s)
	);

	ioexp_cs_hold u_cs_hold (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.cs_n     (~cs_s),
		.cs_held  (cs_held)
	);

	// Pin, power-on and software reset all take the same path.
	assign rst_all = sys_rst | rst_pin_lvl | por_event | sw_reset;

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [23:0] dir_r;
	logic [23:0] dir_nxt;
	logic [23:0] out_r;
	logic [23:0] out_nxt;
	logic [23:0] pol_r;
	logic [23:0] pol_nxt;
	logic [23:0] mask_r;
	logic [23:0] mask_nxt;
	logic [2:0]  smart_r;
	logic [2:0]  smart_nxt;
	logic        fs_r;
	logic        fs_nxt;

	always_comb begin
		dir_nxt   = dir_wr   ? dir_wdata   : dir_r;
		out_nxt   = out_wr   ? out_wdata   : out_r;
		pol_nxt   = pol_wr   ? pol_wdata   : pol_r;
		mask_nxt  = mask_wr  ? mask_wdata  : mask_r;
		smart_nxt = smart_wr ? smart_wdata : smart_r;
		fs_nxt    = fs_r | failsafe_enter;
	end

	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			dir_r   <= ioexp_pkg::DIR_RST;
			out_r   <= ioexp_pkg::OUT_RST;
			pol_r   <= ioexp_pkg::POL_RST;
			mask_r  <= ioexp_pkg::MASK_RST;
			smart_r <= ioexp_pkg::SMART_RST;
			fs_r    <= 1'b0;
		end else begin
			dir_r   <= dir_nxt;
			out_r   <= out_nxt;
			pol_r   <= pol_nxt;
			mask_r  <= mask_nxt;
			smart_r <= smart_nxt;
			fs_r    <= fs_nxt;
		end
	end

	// ****************************************
	// Input capture and flags
	// ****************************************
	logic [23:0] in_r;
	logic [23:0] in_nxt;
	logic [23:0] init_r;
	logic [23:0] init_nxt;
	logic [23:0] flag_r;
	logic [23:0] flag_nxt;
	logic [23:0] late_r;
	logic [23:0] late_nxt;
	logic [23:0] defer_r;
	logic [23:0] defer_nxt;
	logic [5:0]  fault_r;
	logic [5:0]  fault_nxt;

	function automatic logic [23:0] port_expand(input logic [2:0] p);
		logic [23:0] v;
		v = {{8{p[2]}}, {8{p[1]}}, {8{p[0]}}};
		return v;
	endfunction

	// The input register tracks the pin continuously; a change against it is the edge.
	always_comb begin
		logic [23:0] is_in;
		logic [23:0] edge_ev;
		logic [23:0] smart_en;
		logic [23:0] clr_now;
		logic [23:0] back;
		is_in    = ~dir_r;
		smart_en = ~port_expand(smart_r);
		in_nxt   = pin_s;
		// Edges on inputs only; a pin just turned input compares with its stored value.
		// A mask written in this cycle already blocks an edge, so a masked flag never sets.
		edge_ev  = (pin_s ^ in_r) & is_in & ~mask_nxt;
		back     = (pin_s == init_r) ? 24'hFFFFFF : ~(pin_s ^ init_r);
		clr_now  = 24'h000000;
		late_nxt = late_r;
		defer_nxt = defer_r;
		init_nxt = init_r;
		// Smart clears: immediate if select was high at the change, else deferred.
		clr_now  = clr_now | (smart_en & ~late_r & (back | {24{input_rd}}));
		defer_nxt = defer_r | (smart_en & late_r & (back | {24{input_rd}}));
		clr_now  = clr_now | (defer_r & {24{cs_held}});
		if (cs_held) begin
			defer_nxt = 24'h000000;
		end
		if (flag_rd) begin
			clr_now = clr_now | flag_r;
		end
		if (mask_wr) begin
			clr_now = clr_now | mask_wdata;
		end
		if (fs_nxt) begin
			clr_now = 24'hFFFFFF;
		end
		clr_now  = clr_now & flag_r;
		// A new edge wins over a smart or flag-read clear in the same cycle.
		flag_nxt = (flag_r & ~clr_now) | (edge_ev & {24{~fs_nxt}});
		for (int i = 0; i < ioexp_pkg::PINS; i++) begin
			if (edge_ev[i] && !flag_r[i]) begin
				init_nxt[i] = in_r[i];
				late_nxt[i] = cs_s;
			end
		end
		late_nxt  = late_nxt & flag_nxt;
		defer_nxt = defer_nxt & flag_nxt;
		fault_nxt = fault_q_clear(fault_r, fault_rd);
		fault_nxt[ioexp_pkg::FAULT_SYNC] = fault_nxt[ioexp_pkg::FAULT_SYNC] |
			(redund_chk_en & redund_mismatch);
		fault_nxt[ioexp_pkg::FAULT_POR] = fault_nxt[ioexp_pkg::FAULT_POR] | ~por_seen_r;
	end

	function automatic logic [5:0] fault_q_clear(input logic [5:0] f, input logic rd);
		return rd ? 6'h00 : f;
	endfunction

	// Power-on recovery marker: set at the first clock after a power-on reset.
	assign por_seen_nxt = 1'b1;

	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			in_r    <= ioexp_pkg::FLAG_RST;
			init_r  <= ioexp_pkg::FLAG_RST;
			flag_r  <= ioexp_pkg::FLAG_RST;
			late_r  <= ioexp_pkg::FLAG_RST;
			defer_r <= ioexp_pkg::FLAG_RST;
		end else begin
			in_r    <= in_nxt;
			init_r  <= init_nxt;
			flag_r  <= flag_nxt;
			late_r  <= late_nxt;
			defer_r <= defer_nxt;
		end
	end

	// Fault bits survive the pin reset so the power-on fault can re-assert.
	always_ff @(posedge core_clk) begin
		if (sys_rst || por_event) begin
			por_seen_r <= 1'b0;
			fault_r    <= 6'h00;
		end else begin
			por_seen_r <= por_seen_nxt;
			fault_r    <= fault_nxt;
		end
	end

	// ****************************************
	// Pin drive, interrupt and read back
	// ****************************************
	logic [23:0] port_flags;
	logic        irq;

	// Flags of pins now outputs are kept but do not reach the pin.
	assign port_flags = flag_r & ~dir_r;
	assign irq = !fs_r && ((|port_flags) || (|fault_r));

	always_ff @(posedge core_clk) begin
		if (rst_all) begin
			pin_out  <= 24'h000000;
			pin_oe   <= 24'h000000;
			int_out  <= 1'b0;
			int_oe   <= 1'b0;
			dir_q    <= ioexp_pkg::DIR_RST;
			out_q    <= ioexp_pkg::OUT_RST;
			pol_q    <= ioexp_pkg::POL_RST;
			mask_q   <= ioexp_pkg::MASK_RST;
			smart_q  <= ioexp_pkg::SMART_RST;
			input_q  <= 24'h000000;
			flag_q   <= ioexp_pkg::FLAG_RST;
			fault_q  <= 6'h00;
			spi_init <= 1'b1;
		end else begin
			pin_out  <= out_r;
			pin_oe   <= dir_r;
			int_out  <= 1'b0;
			int_oe   <= irq;
			dir_q    <= dir_r;
			out_q    <= out_r;
			pol_q    <= pol_r;
			mask_q   <= mask_r;
			smart_q  <= smart_r;
			input_q  <= in_r ^ pol_r;
			flag_q   <= flag_r;
			fault_q  <= fault_r;
			spi_init <= 1'b0;
		end
	end
endmodule // io_expander_port_interrupt_core

// file: hdl/ioexp_cs_hold.sv
// Chip select watcher: flags when select has stayed high long enough.
`timescale 1ns/1ns
module ioexp_cs_hold (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// Chip select, already synchronised, active low
	input  wire logic cs_n,
	// High while select has been high for over the hold time
	output logic      cs_held
);
	ioexp_pkg::cs_state_t st_r;
	ioexp_pkg::cs_state_t st_nxt;
	logic [7:0]           cnt_r;
	logic [7:0]           cnt_nxt;

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			ioexp_pkg::CS_IDLE: begin
				if (!cs_n) begin
					st_nxt = ioexp_pkg::CS_ACTIVE;
				end
			end
			ioexp_pkg::CS_ACTIVE: begin
				if (cs_n) begin
					st_nxt  = ioexp_pkg::CS_HOLDING;
					cnt_nxt = 8'h01;
				end
			end
			ioexp_pkg::CS_HOLDING: begin
				if (!cs_n) begin
					st_nxt = ioexp_pkg::CS_ACTIVE;
				end else if (cnt_r >= 8'(ioexp_pkg::CS_HOLD_CYC)) begin
					st_nxt = ioexp_pkg::CS_IDLE;
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
			default: st_nxt = ioexp_pkg::CS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r  <= ioexp_pkg::CS_IDLE;
			cnt_r <= 8'h00;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign cs_held = (st_r == ioexp_pkg::CS_IDLE);
endmodule // ioexp_cs_hold

// file: hdl/ioexp_pkg.sv
// Shared constants for the I/O expander port and interrupt core.
package ioexp_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int PORTS = 3;
	localparam int PINS  = 24;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [23:0] DIR_RST    = 24'h000000;
	localparam logic [23:0] OUT_RST    = 24'h000000;
	localparam logic [23:0] POL_RST    = 24'h000000;
	localparam logic [23:0] MASK_RST   = 24'h000000;
	localparam logic [23:0] FLAG_RST   = 24'h000000;
	localparam logic [2:0]  SMART_RST  = 3'h0;
	localparam int          CLK_HZ     = 20000000;
	localparam int          CS_HOLD_NS = 30;
	// More than 30 ns means a strict count: floor plus one.
	localparam int          CS_HOLD_CYC = (CS_HOLD_NS * (CLK_HZ / 1000000)) / 1000 + 1;
	localparam int          SYNC_DEPTH = 3;
	localparam int          FAULT_POR  = 0;
	localparam int          FAULT_SYNC = 1;
	localparam int          FAULT_BITS = 6;
	typedef enum logic [1:0] {
		CS_IDLE,
		CS_ACTIVE,
		CS_HOLDING
	} cs_state_t;
endpackage

// file: hdl/ioexp_sync.sv
// Three-stage synchroniser with agreement check for pin inputs.
`timescale 1ns/1ns
module ioexp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	logic [W-1:0] out_nxt;

	// A bit only changes once the second and third stage agree.
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_comb begin
				out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			out_r <= '0;
		end else begin
			s1_r  <= async_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign sync_out = out_r;
endmodule // ioexp_sync

// file: testbench/io_expander_port_interrupt_core_test.sv
// Self-checking bench for the port and interrupt core.
`timescale 1ns/1ns
module io_expander_port_interrupt_core_test;
	// ****************************************
	// Bench
	// ****************************************
	localparam int DIR = 0, OUTR = 1, POL = 2, MSK = 3, SMT = 4, IRD = 5, FRD = 6, XRD = 7;
	logic        core_clk, sys_rst, reset_pin_n, por_event;
	logic        failsafe_enter, redund_chk_en, redund_mismatch;
	logic [7:0]  stb;
	logic [23:0] wd, ext;
	wire         cs_n, sw_reset;
	wire  [23:0] pin_in;
	logic [23:0] pin_out, pin_oe, dir_q, out_q, pol_q, mask_q, input_q, flag_q;
	logic [2:0]  smart_q;
	logic [5:0]  fault_q;
	logic        int_out, int_oe, spi_init;
	int          err_count, check_count;
	// Driven pins show the core's own level; the bench only drives floating ones.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
	always #25 core_clk = ~core_clk;
	io_expander_port_interrupt_core DUT (
		.core_clk, .sys_rst, .reset_pin_n, .por_event, .sw_reset, .cs_n,
		.dir_wr(stb[0]), .dir_wdata(wd), .out_wr(stb[1]), .out_wdata(wd),
		.pol_wr(stb[2]), .pol_wdata(wd), .mask_wr(stb[3]), .mask_wdata(wd),
		.smart_wr(stb[4]), .smart_wdata(wd[2:0]), .input_rd(stb[5]),
		.flag_rd(stb[6]), .fault_rd(stb[7]), .failsafe_enter, .redund_chk_en,
		.redund_mismatch, .pin_in, .pin_out, .pin_oe, .int_out, .int_oe, .dir_q,
		.out_q, .pol_q, .mask_q, .smart_q, .input_q, .flag_q, .fault_q, .spi_init
	);
	spi_host_model host (.core_clk, .cs_n, .sw_reset);
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(input int k, input logic [23:0] d);
		@(posedge core_clk);
		stb[k] <= 1'b1;
		wd <= d;
		@(posedge core_clk);
		stb <= 8'h00;
		tick(4);
	endtask
	task automatic setp(input int b, input logic v);
		@(posedge core_clk);
		ext[b] <= v;
	endtask
	task automatic wait_int(input logic v);
		int n;
		n = 0;
		while (int_oe !== v && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		chk("int_oe", {23'h000000, int_oe}, {23'h000000, v});
		if (n == 40) close_out();
	endtask
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		reset_pin_n = 1'b1;
		por_event = 1'b0;
		failsafe_enter = 1'b0;
		redund_chk_en = 1'b0;
		redund_mismatch = 1'b0;
		stb = 8'h00;
		wd = 24'h000000;
		ext = 24'h000000;
		err_count = 0;
		check_count = 0;
		tick(5);
		sys_rst <= 1'b0;
		wait_int(1'b1);
		chk("pin_oe", pin_oe, 24'h000000);
		chk("mask_q", mask_q, 24'h000000);
		chk("fault_q", {18'h00000, fault_q}, 24'h000001);
		acc(MSK, 24'hFFFFFF);
		wait_int(1'b1);
		acc(MSK, 24'h000000);
		acc(XRD, 24'h000000);
		wait_int(1'b0);
		acc(OUTR, 24'h0000A5);
		chk("out_q", out_q, 24'h0000A5);
		acc(DIR, 24'h00000F);
		chk("dir_q", dir_q, 24'h00000F);
		chk("pin_oe", pin_oe, 24'h00000F);
		chk("pin_out", pin_out & pin_oe, 24'h000005);
		acc(POL, 24'hFF0000);
		chk("pol_q", pol_q, 24'hFF0000);
		chk("input_q", input_q, 24'hFF0005);
		setp(8, 1'b1);
		wait_int(1'b1);
		chk("flag_q", flag_q, 24'h000100);
		setp(8, 1'b0);
		wait_int(1'b0);
		setp(8, 1'b1);
		wait_int(1'b1);
		acc(IRD, 24'h000000);
		wait_int(1'b0);
		setp(8, 1'b0);
		wait_int(1'b1);
		acc(FRD, 24'h000000);
		wait_int(1'b0);
		acc(OUTR, 24'h0000A7);
		tick(10);
		chk("flag_q", flag_q, 24'h000000);
		acc(DIR, 24'h00000D);
		wait_int(1'b1);
		chk("flag_q", flag_q, 24'h000002);
		acc(FRD, 24'h000000);
		wait_int(1'b0);
		acc(DIR, 24'h00000F);
		acc(SMT, 24'h000007);
		chk("smart_q", {21'h000000, smart_q}, 24'h000007);
		setp(9, 1'b1);
		wait_int(1'b1);
		setp(9, 1'b0);
		tick(10);
		chk("flag_q", flag_q, 24'h000200);
		acc(DIR, 24'h00020F);
		wait_int(1'b0);
		chk("flag_q", flag_q, 24'h000200);
		acc(DIR, 24'h00000F);
		wait_int(1'b1);
		acc(FRD, 24'h000000);
		wait_int(1'b0);
		setp(10, 1'b1);
		wait_int(1'b1);
		acc(MSK, 24'h000400);
		wait_int(1'b0);
		setp(10, 1'b0);
		tick(10);
		chk("flag_q", flag_q, 24'h000000);
		acc(MSK, 24'h000000);
		acc(SMT, 24'h000000);
		fork
			host.send(24'h000000);
			begin
				tick(20);
				setp(11, 1'b1);
				wait_int(1'b1);
				setp(11, 1'b0);
				tick(20);
				chk("flag_q", flag_q, 24'h000800);
			end
		join
		wait_int(1'b0);
		redund_mismatch <= 1'b1;
		tick(10);
		chk("fault_q", {18'h00000, fault_q}, 24'h000000);
		redund_chk_en <= 1'b1;
		wait_int(1'b1);
		chk("fault_q", {18'h00000, fault_q}, 24'h000002);
		redund_mismatch <= 1'b0;
		redund_chk_en <= 1'b0;
		acc(XRD, 24'h000000);
		wait_int(1'b0);
		acc(OUTR, 24'h000000);
		host.send(24'h1A0002);
		tick(4);
		chk("dir_q", dir_q, 24'h000000);
		chk("pin_oe", pin_oe, 24'h000000);
		acc(SMT, 24'h000007);
		setp(12, 1'b1);
		wait_int(1'b1);
		setp(12, 1'b0);
		tick(10);
		reset_pin_n <= 1'b0;
		tick(10);
		chk("flag_q", flag_q, 24'h000000);
		chk("spi_init", {23'h000000, spi_init}, 24'h000001);
		reset_pin_n <= 1'b1;
		tick(10);
		chk("smart_q", {21'h000000, smart_q}, 24'h000000);
		acc(XRD, 24'h000000);
		por_event <= 1'b1;
		tick(1);
		por_event <= 1'b0;
		wait_int(1'b1);
		chk("fault_q", {18'h00000, fault_q}, 24'h000001);
		acc(XRD, 24'h000000);
		wait_int(1'b0);
		setp(13, 1'b1);
		wait_int(1'b1);
		failsafe_enter <= 1'b1;
		tick(1);
		failsafe_enter <= 1'b0;
		wait_int(1'b0);
		chk("flag_q", flag_q, 24'h000000);
		close_out();
	end
endmodule // io_expander_port_interrupt_core_test

// file: testbench/ioexp_core_props.sv
// Concurrent checks on the ports of the port and interrupt core.
`timescale 1ns/1ns
module ioexp_core_props (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Inputs watched
	input wire logic        reset_pin_n,
	input wire logic        sw_reset,
	input wire logic        mask_wr,
	input wire logic [23:0] mask_wdata,
	input wire logic        fault_rd,
	input wire logic        redund_chk_en,
	input wire logic        redund_mismatch,
	// Outputs watched
	input wire logic [23:0] pin_oe,
	input wire logic        int_out,
	input wire logic        int_oe,
	input wire logic [23:0] dir_q,
	input wire logic [23:0] flag_q,
	input wire logic [5:0]  fault_q,
	input wire logic        spi_init
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	property p_rst_load;
		$fell(sys_rst) |-> (pin_oe == 24'h000000 && flag_q == 24'h000000);
	endproperty
	a_rst_load: assert property (p_rst_load) else $error("state left after reset");
	property p_int_od;
		int_out == 1'b0;
	endproperty
	a_int_od: assert property (p_int_od) else $error("interrupt line driven high");
	property p_int_on;
		$rose(|(flag_q & ~dir_q)) |-> ##[0:2] int_oe;
	endproperty
	a_int_on: assert property (p_int_on) else $error("flag without interrupt");
	// Allow one cycle; direction read-back and int_oe are registered on the same clock edge.
	property p_int_off;
		$fell(int_oe) |-> ##[0:1] ((flag_q & ~dir_q) == 24'h000000);
	endproperty
	a_int_off: assert property (p_int_off) else $error("interrupt dropped early");
	property p_mask_clr;
		mask_wr |-> ##2 ((flag_q & $past(mask_wdata, 2)) == 24'h000000);
	endproperty
	a_mask_clr: assert property (p_mask_clr) else $error("masked flag kept");
	property p_fault_hold;
		$fell(fault_q[0]) |-> ($past(fault_rd, 2) || spi_init);
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault cleared unread");
	property p_sync_set;
		redund_chk_en && redund_mismatch |-> ##[1:6] fault_q[1];
	endproperty
	a_sync_set: assert property (p_sync_set) else $error("sync fault missing");
	property p_sw_rst;
		sw_reset |-> ##[1:2] spi_init;
	endproperty
	a_sw_rst: assert property (p_sw_rst) else $error("serial restart missing");
	property p_pin_rst;
		(!reset_pin_n) [*8] |-> (spi_init && flag_q == 24'h000000);
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");
	c_int: cover property ($rose(int_oe));
	c_fault: cover property ($fell(fault_q[0]));
	c_sw: cover property (sw_reset);
endmodule // ioexp_core_props

bind io_expander_port_interrupt_core ioexp_core_props u_props (
	.core_clk, .sys_rst, .reset_pin_n, .sw_reset, .mask_wr, .mask_wdata,
	.fault_rd, .redund_chk_en, .redund_mismatch, .pin_oe, .int_out, .int_oe,
	.dir_q, .flag_q, .fault_q, .spi_init
);

// file: testbench/spi_host_model.sv
// Serial controller stand-in: frames chip select and decodes a reset command.
`timescale 1ns/1ns
module spi_host_model (
	// Clock
	input  wire logic core_clk,
	// Controller side of the link
	output logic      cs_n,
	output logic      sw_reset
);
	// ****************************************
	// Frames
	// ****************************************
	initial begin
		cs_n = 1'b1;
		sw_reset = 1'b0;
	end
	// A frame lasts 24 link clocks of 400 ns; select idles high between frames.
	task automatic send(input logic [23:0] word);
		@(posedge core_clk);
		cs_n <= 1'b0;
		repeat (192) @(posedge core_clk);
		cs_n <= 1'b1;
		if (word === 24'h1A0002) begin
			sw_reset <= 1'b1;
			@(posedge core_clk);
			sw_reset <= 1'b0;
		end
	endtask
endmodule // spi_host_model
